//--- hw/legacy_sideband_regs.svh
// Constants for the legacy sideband block
`ifndef LEGACY_SIDEBAND_REGS_SVH
`define LEGACY_SIDEBAND_REGS_SVH

`define RESET_VECTOR 32'hffff_fff0
`define SUPPLY_SYNC_STAGES 2
`define IRQ_CTRL_EN_RESET 1'b1

`endif

//--- hw/legacy_sideband_pkg.sv
// Types for the legacy sideband block
package legacy_sideband_pkg;

    typedef enum logic [1:0] {
        ST_FULL_RUN = 2'b00,
        ST_STOP_GRANT = 2'b01,
        ST_DEEP_SLEEP = 2'b10,
        ST_POWER_DOWN = 2'b11
    } power_state_type;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_INIT_HOLD = 2'b01,
        ST_INIT_RESTART = 2'b10
    } init_state_type;

    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic released;
    } supply_sync_type;

    typedef struct packed {
        power_state_type power;
        init_state_type init;
        logic break_q;
        logic irq_ctrl_en;
        logic maskable;
        logic nonmaskable;
        logic lirq0;
        logic lirq1;
        logic clear_int;
        logic fetch_restart;
        logic [31:0] fetch_addr;
        logic snoop_ack;
        logic int_init;
    } side_state_type;

endpackage

//--- hw/supply_good_sync.sv
// Supply-good synchroniser producing the internal reset release
`timescale 1ns/1ns
`default_nettype none

module supply_good_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic supply_good_in,
    output logic core_rst_n
);
    import legacy_sideband_pkg::*;

    supply_sync_type s_q;
    supply_sync_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.sync_a = supply_good_in;
        s_d.sync_b = s_q.sync_a;
        // Release only once the synchronised level is high
        s_d.released = s_q.sync_b;
        if (!s_q.sync_b) begin
            s_d.released = 1'b0;
        end
    end

    // Dropping supply_good clears the chain at once
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else if (!supply_good_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign core_rst_n = s_q.released;

endmodule // supply_good_sync

`default_nettype wire

//--- hw/legacy_sideband.sv
// Legacy sideband pin handling for the processor core
`timescale 1ns/1ns
`default_nettype none

`include "legacy_sideband_regs.svh"

module legacy_sideband (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic supply_good_in,
    input wire logic stop_clock_in,
    input wire logic soft_init_in,
    input wire logic local_irq0,
    input wire logic local_irq1,
    input wire logic break_event,
    input wire logic deep_sleep_req,
    input wire logic power_down_req,
    input wire logic irq_ctrl_cfg_we,
    input wire logic irq_ctrl_cfg_en,
    input wire logic snoop_req,
    output logic snoop_ack,
    output logic pending_break_out,
    output logic pending_break_oe,
    output logic maskable_irq,
    output logic nonmaskable_irq,
    output logic local_irq0_out,
    output logic local_irq1_out,
    output logic int_reg_clear,
    output logic fetch_restart,
    output logic [31:0] fetch_addr,
    output legacy_sideband_pkg::power_state_type power_state,
    output logic core_rst_n
);
    import legacy_sideband_pkg::*;

    side_state_type st_q;
    side_state_type st_d;
    logic core_rst_int;

    ////////////////////////////////////////////////////////////////////////
    // Supply good qualification

    supply_good_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .supply_good_in(supply_good_in),
        .core_rst_n(core_rst_int)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_d = st_q;
        st_d.clear_int = 1'b0;
        st_d.fetch_restart = 1'b0;
        // Snoops answered in every state, soft init included
        st_d.snoop_ack = snoop_req;

        case (st_q.power)
            ST_FULL_RUN: begin
                if (stop_clock_in) begin
                    st_d.power = ST_STOP_GRANT;
                end
            end
            ST_STOP_GRANT: begin
                if (!stop_clock_in) begin
                    st_d.power = ST_FULL_RUN;
                end else if (power_down_req) begin
                    st_d.power = ST_POWER_DOWN;
                end else if (deep_sleep_req) begin
                    st_d.power = ST_DEEP_SLEEP;
                end
            end
            ST_DEEP_SLEEP, ST_POWER_DOWN: begin
                if (!stop_clock_in) begin
                    st_d.power = ST_FULL_RUN;
                end
            end
            default: st_d.power = ST_FULL_RUN;
        endcase

        // Break request honoured in any low-power state
        st_d.break_q = stop_clock_in && break_event;

        case (st_q.init)
            ST_RUN: begin
                if (soft_init_in) begin
                    st_d.init = ST_INIT_HOLD;
                    st_d.clear_int = 1'b1;
                end
            end
            ST_INIT_HOLD: begin
                if (!soft_init_in) begin
                    st_d.init = ST_INIT_RESTART;
                end
            end
            ST_INIT_RESTART: begin
                st_d.init = ST_RUN;
                st_d.fetch_restart = 1'b1;
                st_d.fetch_addr = `RESET_VECTOR;
            end
            default: st_d.init = ST_RUN;
        endcase
        st_d.int_init = (st_d.init != ST_RUN);

        if (irq_ctrl_cfg_we) begin
            st_d.irq_ctrl_en = irq_ctrl_cfg_en;
        end

        // Pin routing by controller enable
        st_d.maskable = !st_q.irq_ctrl_en && local_irq0;
        st_d.nonmaskable = !st_q.irq_ctrl_en && local_irq1;
        st_d.lirq0 = st_q.irq_ctrl_en && local_irq0;
        st_d.lirq1 = st_q.irq_ctrl_en && local_irq1;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, loaded with reset values while supply is not good

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.irq_ctrl_en <= `IRQ_CTRL_EN_RESET;
            st_q.fetch_addr <= `RESET_VECTOR;
        end else if (!core_rst_int) begin
            st_q <= '0;
            st_q.irq_ctrl_en <= `IRQ_CTRL_EN_RESET;
            st_q.fetch_addr <= `RESET_VECTOR;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Open drain: drive low only when requesting a break
    assign pending_break_out = 1'b0;
    assign pending_break_oe = st_q.break_q && stop_clock_in;
    assign snoop_ack = st_q.snoop_ack;
    assign maskable_irq = st_q.maskable;
    assign nonmaskable_irq = st_q.nonmaskable;
    assign local_irq0_out = st_q.lirq0;
    assign local_irq1_out = st_q.lirq1;
    assign int_reg_clear = st_q.clear_int;
    assign fetch_restart = st_q.fetch_restart;
    assign fetch_addr = st_q.fetch_addr;
    assign power_state = st_q.power;
    assign core_rst_n = core_rst_int;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_break_needs_stop;
        @(posedge sys_clk) disable iff (!rst_n)
        !stop_clock_in |-> !pending_break_oe;
    endproperty
    a_break_needs_stop: assert property (p_break_needs_stop) else $error("break asserted without stop clock");

    property p_break_in_sleep;
        @(posedge sys_clk) disable iff (!rst_n || !core_rst_int)
        (stop_clock_in && break_event && st_q.power == ST_POWER_DOWN) ##1 stop_clock_in |-> pending_break_oe;
    endproperty
    a_break_in_sleep: assert property (p_break_in_sleep) else $error("break not raised from power down");

    property p_init_clear;
        @(posedge sys_clk) disable iff (!rst_n || !core_rst_int)
        (st_q.init == ST_RUN && soft_init_in) |=> int_reg_clear;
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("integer clear missing on soft init");

    property p_init_restart;
        @(posedge sys_clk) disable iff (!rst_n || !core_rst_int)
        (st_q.init == ST_INIT_HOLD && !soft_init_in) |=> ##1 (fetch_restart && fetch_addr == `RESET_VECTOR);
    endproperty
    a_init_restart: assert property (p_init_restart) else $error("no restart at reset vector");

    property p_snoop;
        @(posedge sys_clk) disable iff (!rst_n || !core_rst_int)
        (soft_init_in && snoop_req) |=> snoop_ack;
    endproperty
    a_snoop: assert property (p_snoop) else $error("snoop dropped during soft init");

    property p_maskable;
        @(posedge sys_clk) disable iff (!rst_n || !core_rst_int)
        !st_q.irq_ctrl_en ##0 $stable(st_q.irq_ctrl_en) |=> (maskable_irq == $past(local_irq0) && !local_irq0_out);
    endproperty
    a_maskable: assert property (p_maskable) else $error("local_irq0 not routed as maskable");

    property p_nonmaskable;
        @(posedge sys_clk) disable iff (!rst_n || !core_rst_int)
        !st_q.irq_ctrl_en |=> (nonmaskable_irq == $past(local_irq1));
    endproperty
    a_nonmaskable: assert property (p_nonmaskable) else $error("local_irq1 not routed as nonmaskable");

    property p_ctrl_default;
        @(posedge sys_clk) disable iff (!rst_n)
        !core_rst_int |=> st_q.irq_ctrl_en;
    endproperty
    a_ctrl_default: assert property (p_ctrl_default) else $error("controller not enabled after reset");

    property p_hold_reset;
        @(posedge sys_clk) disable iff (!rst_n)
        !supply_good_in |=> (!core_rst_int ##1 !core_rst_int);
    endproperty
    a_hold_reset: assert property (p_hold_reset) else $error("released without synchronised supply good");

endmodule // legacy_sideband

`default_nettype wire

//--- tb/platform_supply_model.sv
// Platform model that sequences the supply-good level
`timescale 1ns/1ns
`default_nettype none

module platform_supply_model #(
    parameter int STABLE_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic power_on,
    output logic supply_good_in
);
    int count = 0;

    initial supply_good_in = 1'b0;

    // Held low until supplies settle, then one clean rise
    always @(posedge sys_clk) begin
        if (!power_on) begin
            count <= 0;
            supply_good_in <= 1'b0;
        end else if (count < STABLE_CYCLES) begin
            count <= count + 1;
        end else begin
            supply_good_in <= 1'b1;
        end
    end
endmodule // platform_supply_model

`default_nettype wire

//--- tb/legacy_sideband_bench.sv
// Self-checking bench for the legacy sideband block
`timescale 1ns/1ns
`default_nettype none

`include "legacy_sideband_regs.svh"

module legacy_sideband_bench;
    import legacy_sideband_pkg::*;
    logic sys_clk = 0, rst_n = 0, power_on = 1, supply_good_in;
    logic stop_clock_in = 0, soft_init_in = 0, local_irq0 = 0, local_irq1 = 0, break_event = 0;
    logic deep_sleep_req = 0, power_down_req = 0, irq_ctrl_cfg_we = 0, irq_ctrl_cfg_en = 0, snoop_req = 0;
    logic snoop_ack, pending_break_out, pending_break_oe, maskable_irq, nonmaskable_irq;
    logic local_irq0_out, local_irq1_out, int_reg_clear, fetch_restart, core_rst_n;
    logic [31:0] fetch_addr;
    power_state_type power_state;
    int n_errors = 0, tests_run = 0, cycles = 0;
    logic [32:0] exp_q[$];

    platform_supply_model model (.sys_clk(sys_clk), .power_on(power_on), .supply_good_in(supply_good_in));

    legacy_sideband uut (.sys_clk(sys_clk), .rst_n(rst_n), .supply_good_in(supply_good_in),
        .stop_clock_in(stop_clock_in), .soft_init_in(soft_init_in), .local_irq0(local_irq0),
        .local_irq1(local_irq1), .break_event(break_event), .deep_sleep_req(deep_sleep_req),
        .power_down_req(power_down_req), .irq_ctrl_cfg_we(irq_ctrl_cfg_we),
        .irq_ctrl_cfg_en(irq_ctrl_cfg_en), .snoop_req(snoop_req), .snoop_ack(snoop_ack),
        .pending_break_out(pending_break_out), .pending_break_oe(pending_break_oe),
        .maskable_irq(maskable_irq), .nonmaskable_irq(nonmaskable_irq),
        .local_irq0_out(local_irq0_out), .local_irq1_out(local_irq1_out),
        .int_reg_clear(int_reg_clear), .fetch_restart(fetch_restart), .fetch_addr(fetch_addr),
        .power_state(power_state), .core_rst_n(core_rst_n));

    initial begin
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_core();
        repeat (30) if (core_rst_n !== 1'b1) cyc(1);
        check(core_rst_n, 1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Result monitor: pulses consume the oldest note
    always @(posedge sys_clk) begin
        #1;
        if (int_reg_clear === 1'b1 || fetch_restart === 1'b1) begin
            if (exp_q.size() > 0) begin
                check({fetch_restart, fetch_restart ? fetch_addr : 32'h0}, exp_q.pop_front());
            end else begin
                check(1'b1, 1'b0);
            end
        end
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(8));
        cyc(5);
        rst_n = 1;
        wait_core();
        $display("reset done");
        for (int en = 1; en >= 0; en--) begin
            repeat (6) begin
                {local_irq1, local_irq0} = 2'($urandom);
                cyc(2);
                check({local_irq1_out, local_irq0_out, nonmaskable_irq, maskable_irq},
                    en ? {local_irq1, local_irq0, 2'b00} : {2'b00, local_irq1, local_irq0});
            end
            irq_ctrl_cfg_en = 0;
            irq_ctrl_cfg_we = 1;
            cyc(1);
            irq_ctrl_cfg_we = 0;
        end
        $display("irq routing done");
        break_event = 1;
        cyc(2);
        check({pending_break_out, pending_break_oe}, 0);
        for (int i = 0; i < 2; i++) begin
            break_event = 0;
            stop_clock_in = 1;
            cyc(2);
            {power_down_req, deep_sleep_req} = i ? 2'b10 : 2'b01;
            cyc(3);
            check(power_state, i ? ST_POWER_DOWN : ST_DEEP_SLEEP);
            break_event = 1;
            // Stop clock held a second cycle so the power-down break check engages
            cyc(2);
            check({pending_break_out, pending_break_oe}, 1);
            {power_down_req, deep_sleep_req} = 2'b00;
            stop_clock_in = 0;
            #1;
            check(pending_break_oe, 0);
            cyc(3);
        end
        break_event = 0;
        $display("break done");
        exp_q.push_back({1'b0, 32'h0});
        exp_q.push_back({1'b1, `RESET_VECTOR});
        soft_init_in = 1;
        snoop_req = 1;
        cyc(2);
        check(snoop_ack, 1);
        cyc(2);
        soft_init_in = 0;
        snoop_req = 0;
        cyc(5);
        check(exp_q.size(), 0);
        $display("soft init done");
        power_on = 0;
        local_irq0 = 1;
        cyc(3);
        check({core_rst_n, int_reg_clear, fetch_restart, maskable_irq}, 0);
        power_on = 1;
        wait_core();
        cyc(2);
        check({local_irq0_out, maskable_irq}, 2'b10);
        $display("supply cycle done");
        complete_run();
    end
endmodule // legacy_sideband_bench

`default_nettype wire
